// file: rtl/dcf_pkg.sv
// Constants and types of the clock fan-out output gating block.
// Assumes a 40 MHz system clock and a two-line serial host at up to 100 kHz.
//
// Notes on behaviour
// - Reference pair fans out to ten output pairs and one loop pair.
// - Clearing a pair's enable bit releases both lines of that pair.
// - The loop drive pair is always driven; nothing can disable it.
// - Enable changes land only while the clock is low: no runt pulses.
// - Bypass select low turns the loop off and passes the reference straight.
// - Serial data is sampled on serial clock rises into the enable register.
// - The serial data line is two-way; the block drives acknowledge bits.
// - Byte zero bits 7..0 map pairs 0..7; byte one bits 7,6 pairs 8,9.
package dcf_pkg;
    localparam int unsigned NUM_PAIRS = 10;
    localparam logic [6:0] DEV_ADDR = 7'h69;
    localparam logic [2:0] IDX_ADDR = 3'h0;
    localparam logic [2:0] IDX_EN0 = 3'h3;
    localparam logic [2:0] IDX_EN1 = 3'h4;
    localparam logic [2:0] IDX_LAST = 3'h7;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] EN0_RESET = 8'hff;
    localparam logic [7:0] EN1_RESET = 8'hc0;
    localparam logic [7:0] EN1_USED_MASK = 8'hc0;
    localparam int unsigned GATE_LATENCY_MAX = 40;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_ACK = 2'b10
    } dcf_state_t;
endpackage : dcf_pkg

// file: rtl/dcf_ser_if.sv
// Carrier between the serial receiver and the top module.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
`default_nettype none
interface dcf_ser_if;
    logic scl_s;
    logic sda_s;
    logic sda_oe;
    logic wr_pulse;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;

    modport rx
    (
        input scl_s, sda_s,
        output sda_oe, wr_pulse, wr_idx, wr_data
    );
    modport core
    (
        output scl_s, sda_s,
        input sda_oe, wr_pulse, wr_idx, wr_data
    );
endinterface : dcf_ser_if
`default_nettype wire

// file: rtl/dcf_serial_rx.sv
// Two-line serial write receiver, oversampled on the system clock.
// Assumes line levels arrive already synchronised.
`timescale 1ns/10ps
`default_nettype none
module dcf_serial_rx
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    dcf_ser_if.rx bus
);
    // ==========================================
    // Line events
    logic scl_d_reg;
    logic sda_d_reg;
    wire scl_rise = bus.scl_s & ~scl_d_reg;
    wire scl_fall = ~bus.scl_s & scl_d_reg;
    wire start_ev = bus.scl_s & scl_d_reg & sda_d_reg & ~bus.sda_s;
    wire stop_ev = bus.scl_s & scl_d_reg & ~sda_d_reg & bus.sda_s;

    // ==========================================
    // Byte engine
    dcf_pkg::dcf_state_t state_reg, state_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] bit_reg, bit_next;
    logic [2:0] idx_reg, idx_next;
    logic oe_reg, oe_next;
    logic wr_reg, wr_next;
    logic [7:0] data_reg, data_next;
    logic [2:0] widx_reg, widx_next;

    wire byte_done = (bit_reg == dcf_pkg::BITS_PER_BYTE) & scl_fall;
    wire addr_ok = (shift_reg[7:1] == dcf_pkg::DEV_ADDR) & ~shift_reg[0];
    wire refuse = (idx_reg == dcf_pkg::IDX_ADDR) & ~addr_ok;
    wire commit = (idx_reg == dcf_pkg::IDX_EN0) | (idx_reg == dcf_pkg::IDX_EN1);

    always_comb
    begin
        state_next = state_reg;
        shift_next = shift_reg;
        bit_next = bit_reg;
        idx_next = idx_reg;
        oe_next = oe_reg;
        wr_next = 1'b0;
        data_next = data_reg;
        widx_next = widx_reg;
        if (start_ev)
        begin
            state_next = dcf_pkg::ST_SHIFT;
            bit_next = 4'h0;
            idx_next = dcf_pkg::IDX_ADDR;
            oe_next = 1'b0;
        end
        else if (stop_ev)
        begin
            state_next = dcf_pkg::ST_IDLE;
            oe_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                dcf_pkg::ST_SHIFT:
                begin
                    if (scl_rise)
                    begin
                        shift_next = {shift_reg[6:0], bus.sda_s};
                        bit_next = bit_reg + 4'h1;
                    end
                    if (byte_done)
                    begin
                        // Wrong address or a read: stay off the line
                        state_next = refuse ? dcf_pkg::ST_IDLE : dcf_pkg::ST_ACK;
                        oe_next = ~refuse;
                    end
                end
                dcf_pkg::ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_next = 1'b0;
                        bit_next = 4'h0;
                        state_next = dcf_pkg::ST_SHIFT;
                        wr_next = commit;
                        data_next = shift_reg;
                        widx_next = idx_reg;
                        // Bytes past the last enable byte are acked and dropped
                        idx_next = (idx_reg == dcf_pkg::IDX_LAST) ? idx_reg : idx_reg + 3'h1;
                    end
                end
                default:
                begin
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            state_reg <= dcf_pkg::ST_IDLE;
            shift_reg <= 8'h00;
            bit_reg <= 4'h0;
            idx_reg <= 3'h0;
            oe_reg <= 1'b0;
            wr_reg <= 1'b0;
            data_reg <= 8'h00;
            widx_reg <= 3'h0;
        end
        else if (ce)
        begin
            scl_d_reg <= bus.scl_s;
            sda_d_reg <= bus.sda_s;
            state_reg <= state_next;
            shift_reg <= shift_next;
            bit_reg <= bit_next;
            idx_reg <= idx_next;
            oe_reg <= oe_next;
            wr_reg <= wr_next;
            data_reg <= data_next;
            widx_reg <= widx_next;
        end
    end

    assign bus.sda_oe = oe_reg;
    assign bus.wr_pulse = wr_reg;
    assign bus.wr_idx = widx_reg;
    assign bus.wr_data = data_reg;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_byte_end;
        ce && state_reg == dcf_pkg::ST_SHIFT && byte_done && !start_ev && !stop_ev;
    endsequence

    a_ack_on_match: assert property (s_byte_end ##0 !refuse |=> oe_reg)
        else $error("acknowledge not driven after accepted byte");
    a_no_ack_foreign: assert property (s_byte_end ##0 refuse |=> !oe_reg ##1 !oe_reg)
        else $error("foreign address acknowledged");
    a_ack_release: assert property (ce && state_reg == dcf_pkg::ST_ACK && scl_fall
        && !start_ev && !stop_ev |=> !oe_reg && state_reg == dcf_pkg::ST_SHIFT)
        else $error("acknowledge not released on clock fall");
    a_commit_whole: assert property (wr_reg |-> $past(state_reg) == dcf_pkg::ST_ACK
        && $past(bit_reg) == dcf_pkg::BITS_PER_BYTE)
        else $error("enable byte committed before acknowledge");
    a_stop_idle: assert property (ce && stop_ev && !start_ev
        |=> state_reg == dcf_pkg::ST_IDLE && !oe_reg)
        else $error("stop condition not honoured");
endmodule : dcf_serial_rx
`default_nettype wire

// file: rtl/dcf_top.sv
// Top of the clock fan-out output gating block.
// Assumes the reference clock pair is a free-running clock; serial pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module dcf_top
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic SERIAL_CLOCK_IN,
    input wire logic SERIAL_CTRL_LINE_IN,
    output logic SERIAL_CTRL_LINE_OUT,
    output logic SERIAL_CTRL_LINE_OE,
    input wire logic REF_CLOCK_TRUE_IN,
    input wire logic REF_CLOCK_COMP_IN,
    input wire logic PLL_SUPPLY_BYPASS_SELECT_N,
    output logic [9:0] FANOUT_TRUE_OUT,
    output logic [9:0] FANOUT_COMP_OUT,
    output logic [9:0] FANOUT_OE,
    output logic LOOP_DRIVE_TRUE_OUT,
    output logic LOOP_DRIVE_COMP_OUT,
    output logic LOOP_DRIVE_OE,
    output logic PLL_ON,
    output logic [9:0] ENABLE_STATE
);
    // ==========================================
    // Pin synchronisers
    logic scl_meta_reg, scl_sync_reg;
    logic sda_meta_reg, sda_sync_reg;
    logic byp_meta_reg, byp_sync_reg;

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            byp_meta_reg <= 1'b1;
            byp_sync_reg <= 1'b1;
        end
        else if (CE)
        begin
            scl_meta_reg <= SERIAL_CLOCK_IN;
            scl_sync_reg <= scl_meta_reg;
            sda_meta_reg <= SERIAL_CTRL_LINE_IN;
            sda_sync_reg <= sda_meta_reg;
            byp_meta_reg <= PLL_SUPPLY_BYPASS_SELECT_N;
            byp_sync_reg <= byp_meta_reg;
        end
    end

    // ==========================================
    // Serial receiver
    dcf_ser_if ser ();
    assign ser.scl_s = scl_sync_reg;
    assign ser.sda_s = sda_sync_reg;

    dcf_serial_rx u_rx
    (
        .clk(CLK),
        .rst_n(RSTN),
        .ce(CE),
        .bus(ser.rx)
    );

    // Open drain: only ever pulls low
    assign SERIAL_CTRL_LINE_OUT = 1'b0;
    assign SERIAL_CTRL_LINE_OE = ser.sda_oe;

    // ==========================================
    // Enable register
    logic [7:0] en0_reg;
    logic [7:0] en1_reg;
    wire wr_en0 = ser.wr_pulse & (ser.wr_idx == dcf_pkg::IDX_EN0);
    wire wr_en1 = ser.wr_pulse & (ser.wr_idx == dcf_pkg::IDX_EN1);

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            en0_reg <= dcf_pkg::EN0_RESET;
            en1_reg <= dcf_pkg::EN1_RESET;
        end
        else if (CE)
        begin
            if (wr_en0)
                en0_reg <= ser.wr_data;
            if (wr_en1)
                en1_reg <= ser.wr_data & dcf_pkg::EN1_USED_MASK;
        end
    end

    logic [9:0] en_vec;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_map0
            assign en_vec[gi] = en0_reg[7 - gi];
        end
    endgenerate
    assign en_vec[8] = en1_reg[7];
    assign en_vec[9] = en1_reg[6];
    assign ENABLE_STATE = en_vec;

    // ==========================================
    // Loop control
    logic pll_on_reg;

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            pll_on_reg <= 1'b1;
        else if (CE)
            pll_on_reg <= byp_sync_reg;
    end
    assign PLL_ON = pll_on_reg;

    // The analogue loop is not modelled; in bypass and in lock the
    // digital view of the outputs is the reference pair itself.
    wire src_true = REF_CLOCK_TRUE_IN;
    wire src_comp = REF_CLOCK_COMP_IN;

    // ==========================================
    // Reference clock domain
    logic rrst_meta_reg;
    logic rrst_n_reg;

    always_ff @(posedge REF_CLOCK_TRUE_IN or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rrst_meta_reg <= 1'b0;
            rrst_n_reg <= 1'b0;
        end
        else
        begin
            rrst_meta_reg <= 1'b1;
            rrst_n_reg <= rrst_meta_reg;
        end
    end

    // Each pair is independent, so per-bit two-flop crossing is enough:
    // bits of one byte may land one reference cycle apart.
    logic [9:0] en_meta_reg;
    logic [9:0] en_sync_reg;
    logic [9:0] gate_reg;

    generate
        for (gi = 0; gi < dcf_pkg::NUM_PAIRS; gi = gi + 1)
        begin : g_pair
            always_ff @(posedge REF_CLOCK_TRUE_IN or negedge rrst_n_reg)
            begin
                if (!rrst_n_reg)
                begin
                    en_meta_reg[gi] <= 1'b1;
                    en_sync_reg[gi] <= 1'b1;
                end
                else
                begin
                    en_meta_reg[gi] <= en_vec[gi];
                    en_sync_reg[gi] <= en_meta_reg[gi];
                end
            end

            // Falling edge update: the true line is low, so a change cuts no pulse
            always_ff @(negedge REF_CLOCK_TRUE_IN or negedge rrst_n_reg)
            begin
                if (!rrst_n_reg)
                    gate_reg[gi] <= 1'b1;
                else
                    gate_reg[gi] <= en_sync_reg[gi];
            end

            assign FANOUT_TRUE_OUT[gi] = src_true;
            assign FANOUT_COMP_OUT[gi] = src_comp;
            assign FANOUT_OE[gi] = gate_reg[gi];
        end
    endgenerate

    assign LOOP_DRIVE_TRUE_OUT = src_true;
    assign LOOP_DRIVE_COMP_OUT = src_comp;
    assign LOOP_DRIVE_OE = 1'b1;

    // ==========================================
    // Checks
    localparam int GATE_MAX = dcf_pkg::GATE_LATENCY_MAX;

    // Gate as it stood at the last true rise; must still hold at the next fall
    logic [9:0] gate_rise_reg;

    always_ff @(posedge REF_CLOCK_TRUE_IN or negedge rrst_n_reg)
    begin
        if (!rrst_n_reg)
            gate_rise_reg <= 10'h3ff;
        else
            gate_rise_reg <= gate_reg;
    end

    a_en0_update: assert property (@(posedge CLK) disable iff (!RSTN)
        CE && wr_en0 |=> en0_reg == $past(ser.wr_data) && ENABLE_STATE[0] == en0_reg[7])
        else $error("byte zero write not applied");
    a_reserved_zero: assert property (@(posedge CLK) disable iff (!RSTN)
        en1_reg[5:0] == 6'h00 && ENABLE_STATE[9] == en1_reg[6])
        else $error("reserved enable bits set");
    a_disable_reaches: assert property (@(posedge CLK) disable iff (!RSTN)
        $fell(en_vec[0]) ##1 !en_vec[0] [*3] |-> ##[1:GATE_MAX] !FANOUT_OE[0])
        else $error("pair zero not released after disable");
    a_gate_low_only: assert property (@(negedge REF_CLOCK_TRUE_IN)
        disable iff (!rrst_n_reg) gate_reg == gate_rise_reg)
        else $error("gate changed while true clock high");
    a_loop_driven: assert property (@(posedge CLK) disable iff (!RSTN)
        LOOP_DRIVE_OE && LOOP_DRIVE_TRUE_OUT == REF_CLOCK_TRUE_IN
        && LOOP_DRIVE_COMP_OUT == REF_CLOCK_COMP_IN)
        else $error("loop drive pair not driven by reference");
    a_bypass_seen: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && !PLL_SUPPLY_BYPASS_SELECT_N) [*4] |=> !PLL_ON)
        else $error("loop not off in bypass");
endmodule : dcf_top
`default_nettype wire

// file: bench/dcf_host_model.sv
// Serial write host standing on the far side of the fan-out gating block.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module dcf_host_model
(
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // Quarter bit time: keeps the bus at 100 kHz
    localparam int Q = 100;
    initial
    begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    // ========================================
    // Bus conditions
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic start_cond;
        sda_low = 1'h0;
        scl = 1'h1;
        tick(Q);
        sda_low = 1'h1;
        tick(Q);
        scl = 1'h0;
        tick(Q);
    endtask : start_cond
    task automatic send_bit(input logic b);
        sda_low = ~b;
        tick(Q);
        scl = 1'h1;
        tick(2 * Q);
        scl = 1'h0;
        tick(Q);
    endtask : send_bit
    // Data released on the ninth clock so the device may answer
    task automatic send_byte(input logic [7:0] b, output logic acked);
        for (int i = 7; i >= 0; i--)
            send_bit(b[i]);
        sda_low = 1'h0;
        tick(Q);
        scl = 1'h1;
        tick(Q);
        acked = (sda === 1'h0);
        tick(Q);
        scl = 1'h0;
        tick(Q);
    endtask : send_byte
    task automatic stop_cond;
        sda_low = 1'h1;
        tick(Q);
        scl = 1'h1;
        tick(Q);
        sda_low = 1'h0;
        tick(2 * Q);
    endtask : stop_cond
    task automatic write_frame(input logic [7:0] b0, input logic [7:0] b1,
        output logic [4:0] acks);
        logic [7:0] seq [5];
        seq = '{8'hd2, 8'h00, 8'h02, b0, b1};
        start_cond();
        for (int i = 0; i < 5; i++)
            send_byte(seq[i], acks[4 - i]);
        stop_cond();
    endtask : write_frame
endmodule : dcf_host_model
`default_nettype wire

// file: bench/dcf_top_tb.sv
// Self-checking bench of the clock fan-out output gating block.
// Assumes dcf_host_model as serial host and a pulled-up data wire.
`timescale 1ns/10ps
`default_nettype none
module dcf_top_tb;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic ref_t = 1'h0;
    logic bypass_n = 1'h1;
    logic ce = 1'h1;
    logic scl;
    logic host_low;
    logic sda_out;
    logic sda_oe;
    logic [9:0] yt, yc, y_oe, en_state;
    logic lt, lc, l_oe, pll_on;
    logic [4:0] acks;
    logic ack;
    int num_errors = 0;
    int checks_done = 0;
    wire sda_wire;
    assign sda_wire = (host_low || (sda_oe && !sda_out)) ? 1'h0 : 1'h1;
    always #12.5 clk = ~clk;
    // Offset keeps reference edges off the system clock edges
    initial
    begin
        #3;
        forever #80 ref_t = ~ref_t;
    end
    dcf_top u_dcf_top (.CLK(clk), .RSTN(rst_n), .CE(ce), .SERIAL_CLOCK_IN(scl),
        .SERIAL_CTRL_LINE_IN(sda_wire), .SERIAL_CTRL_LINE_OUT(sda_out),
        .SERIAL_CTRL_LINE_OE(sda_oe), .REF_CLOCK_TRUE_IN(ref_t), .REF_CLOCK_COMP_IN(~ref_t),
        .PLL_SUPPLY_BYPASS_SELECT_N(bypass_n), .FANOUT_TRUE_OUT(yt), .FANOUT_COMP_OUT(yc),
        .FANOUT_OE(y_oe), .LOOP_DRIVE_TRUE_OUT(lt), .LOOP_DRIVE_COMP_OUT(lc),
        .LOOP_DRIVE_OE(l_oe), .PLL_ON(pll_on), .ENABLE_STATE(en_state));
    dcf_host_model u_dcf_host_model (.clk(clk), .sda(sda_wire), .scl(scl), .sda_low(host_low));
    // ========================================
    // Reporting and comparison
    task automatic give_verdict;
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic cmp_vec(input logic [9:0] got, input logic [9:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_vec
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp_vec({9'h0, got}, {9'h0, exp}, what);
    endtask : cmp_bit
    function automatic logic [9:0] exp_en(input logic [7:0] b0, input logic [7:0] b1);
        logic [9:0] r;
        for (int i = 0; i < 8; i++)
            r[i] = b0[7 - i];
        r[8] = b1[7];
        r[9] = b1[6];
        return r;
    endfunction : exp_en
    // Gate edges may only land while the reference is low
    always @(y_oe)
        if (rst_n === 1'h1)
            cmp_bit(ref_t, 1'h0, "gate moved with clock high");
    always @(negedge clk)
        cmp_bit(l_oe, 1'h1, "loop pair released");
    // ========================================
    // Scenarios
    task automatic wait_oe(input logic [9:0] exp);
        int n;
        n = 0;
        while (y_oe !== exp && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        cmp_vec(y_oe, exp, "pair drive");
        if (n >= 200)
            give_verdict();
    endtask : wait_oe
    task automatic check_copy;
        logic was;
        int n;
        repeat (2)
        begin
            was = ref_t;
            n = 0;
            while (ref_t === was && n < 10)
            begin
                @(negedge clk);
                n++;
            end
            cmp_bit(ref_t, ~was, "reference toggled");
            if (n >= 10)
                give_verdict();
            cmp_vec(yt, {10{ref_t}}, "true copies");
            cmp_vec(yc, {10{~ref_t}}, "comp copies");
            cmp_bit(lt, ref_t, "loop true");
            cmp_bit(lc, ~ref_t, "loop comp");
        end
    endtask : check_copy
    task automatic test_reset;
        rst_n = 1'h0;
        repeat (10) @(negedge clk);
        rst_n = 1'h1;
        repeat (8) @(negedge clk);
        cmp_vec(en_state, 10'h3ff, "reset enables");
        cmp_vec(y_oe, 10'h3ff, "reset drive");
        cmp_bit(pll_on, 1'h1, "reset loop on");
        cmp_bit(sda_oe, 1'h0, "reset data line");
        check_copy();
        $display("test reset done");
    endtask : test_reset
    task automatic test_write(input logic [7:0] b0, input logic [7:0] b1);
        u_dcf_host_model.write_frame(b0, b1, acks);
        cmp_vec({5'h0, acks}, 10'h01f, "acknowledges");
        cmp_vec(en_state, exp_en(b0, b1), "enable bits");
        wait_oe(exp_en(b0, b1));
        check_copy();
        $display("test write %h %h done", b0, b1);
    endtask : test_write
    task automatic test_partial;
        u_dcf_host_model.start_cond();
        u_dcf_host_model.send_byte(8'hd2, ack);
        u_dcf_host_model.send_byte(8'h00, ack);
        u_dcf_host_model.send_byte(8'h02, ack);
        for (int i = 0; i < 4; i++)
            u_dcf_host_model.send_bit(i[0]);
        u_dcf_host_model.stop_cond();
        cmp_vec(en_state, exp_en(8'h5a, 8'h80), "partial byte");
        $display("test partial done");
    endtask : test_partial
    task automatic test_refuse;
        logic [7:0] addr [2];
        addr = '{8'hd4, 8'hd3};
        for (int i = 0; i < 2; i++)
        begin
            u_dcf_host_model.start_cond();
            u_dcf_host_model.send_byte(addr[i], ack);
            cmp_bit(ack, 1'h0, "foreign address");
            u_dcf_host_model.send_byte(8'h00, ack);
            u_dcf_host_model.stop_cond();
            cmp_vec(en_state, exp_en(8'h5a, 8'h80), "ignored frame");
        end
        $display("test refuse done");
    endtask : test_refuse
    task automatic test_bypass;
        // Clock enable low must hold the loop state despite the pin
        ce = 1'h0;
        bypass_n = 1'h0;
        repeat (5) @(negedge clk);
        cmp_bit(pll_on, 1'h1, "loop frozen by enable");
        ce = 1'h1;
        repeat (5) @(negedge clk);
        cmp_bit(pll_on, 1'h0, "bypass loop off");
        check_copy();
        bypass_n = 1'h1;
        repeat (5) @(negedge clk);
        cmp_bit(pll_on, 1'h1, "loop back on");
        $display("test bypass done");
    endtask : test_bypass
    initial
    begin
        test_reset();
        test_write(8'h00, 8'h3f);
        test_write(8'h5a, 8'h80);
        test_partial();
        test_refuse();
        test_bypass();
        // Second reset in mid-run must bring every enable back
        test_reset();
        give_verdict();
    end
endmodule : dcf_top_tb
`default_nettype wire
